// ==== sys_decode.sv ====
`timescale 1ns/1ps
module sys_decode
    import sys_decode_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // instruction byte stream
    input  wire logic        byte_valid,
    input  wire logic [7:0]  byte_data,
    input  wire logic [2:0]  disp_len,       // displacement bytes implied by modrm, from address logic
    input  wire logic        prot_mode,
    input  wire logic        op_size32,
    input  wire logic        iopl_ok,        // privilege check for interrupt enable
    // decoded instruction
    output logic             dec_valid_ff,
    output op_kind_t         dec_kind_ff,
    output logic [5:0]       dec_clocks_ff,
    output logic             dec_fault_ff,   // illegal in this mode or privilege
    output logic [1:0]       dec_size_ff,    // 0 byte, 1 word, 2 dword
    output logic             dec_reg_op_ff,
    output logic [2:0]       dec_rm_ff,
    output logic [7:0]       dec_imm_ff,
    output logic             dec_use_cl_ff,
    output logic [15:0]      dec_flags_ff
);
    // ----------------------------------------------------------------
    // byte sequencer
    // ----------------------------------------------------------------
    dec_state_t state_ff;
    logic       esc_ff;
    logic [7:0] op_ff;
    logic [2:0] disp_cnt_ff;
    logic       done;
    logic [7:0] mrm;
    logic       need_imm;
    logic       has_modrm;

    assign mrm = byte_data;
    // immediate only for c0/c1 and double shifts with immediate
    assign need_imm = esc_ff ? (op_ff == OP_DLS_IMM || op_ff == OP_DRS_IMM) : (op_ff[7:1] == OP_SH_IMM);

    // which opcodes carry a modrm byte
    always_comb begin
        if (state_ff == ST_ESC) begin   // escape flag is stale once back at an opcode byte
            has_modrm = (byte_data != OP_SMENTRY);
        end else begin
            has_modrm = (byte_data[7:1] == OP_SH_ONE) || (byte_data[7:1] == OP_SH_CNT)
                        || (byte_data[7:1] == OP_SH_IMM);
        end
    end

    // state walk through opcode, modrm, displacement, immediate
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_ff    <= ST_OP;
            esc_ff      <= 1'b0;
            op_ff       <= 8'h00;
            disp_cnt_ff <= 3'h0;
        end else if (byte_valid) begin
            case (state_ff)
                ST_OP: begin
                    op_ff <= byte_data;
                    if (byte_data == OP_ESC) begin
                        esc_ff   <= 1'b1;
                        state_ff <= ST_ESC;
                    end else begin
                        esc_ff   <= 1'b0;
                        state_ff <= has_modrm ? ST_MODRM : ST_OP;
                    end
                end
                ST_ESC: begin
                    op_ff    <= byte_data;
                    state_ff <= has_modrm ? ST_MODRM : ST_OP;
                end
                ST_MODRM: begin
                    disp_cnt_ff <= disp_len;
                    if (disp_len != 3'h0) begin
                        state_ff <= ST_DISP;
                    end else begin
                        state_ff <= need_imm ? ST_IMM : ST_OP;
                    end
                end
                ST_DISP: begin
                    disp_cnt_ff <= disp_cnt_ff - 3'h1;
                    if (disp_cnt_ff == 3'h1) begin
                        state_ff <= need_imm ? ST_IMM : ST_OP;
                    end
                end
                ST_IMM: begin
                    state_ff <= ST_OP;   // exactly one immediate byte
                end
                default: begin
                    state_ff <= ST_OP;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // classification
    // ----------------------------------------------------------------
    logic       fin_op;     // opcode without modrm finishes here
    logic       fin_mrm;    // last byte after modrm
    logic [7:0] cur_op;
    logic [2:0] ext_ff;
    logic [1:0] mod_ff;
    logic [2:0] rm_ff;

    assign cur_op  = byte_data;
    assign fin_op  = byte_valid && (state_ff == ST_OP || state_ff == ST_ESC) && !has_modrm
                     && !(state_ff == ST_OP && byte_data == OP_ESC);
    assign fin_mrm = byte_valid && ((state_ff == ST_MODRM && disp_len == 3'h0 && !need_imm)
                     || (state_ff == ST_DISP && disp_cnt_ff == 3'h1 && !need_imm)
                     || state_ff == ST_IMM);
    assign done    = fin_op || fin_mrm;

    // modrm field capture
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mod_ff <= 2'h0;
            ext_ff <= 3'h0;
            rm_ff  <= 3'h0;
        end else if (byte_valid && state_ff == ST_MODRM) begin
            mod_ff <= mrm[7:6];
            ext_ff <= mrm[5:3];
            rm_ff  <= mrm[2:0];
        end
    end

    logic [1:0] c_mod;
    logic [2:0] c_ext;
    logic [2:0] c_rm;
    assign c_mod = (state_ff == ST_MODRM) ? mrm[7:6] : mod_ff;
    assign c_ext = (state_ff == ST_MODRM) ? mrm[5:3] : ext_ff;
    assign c_rm  = (state_ff == ST_MODRM) ? mrm[2:0] : rm_ff;

    op_kind_t   nxt_kind;
    logic [5:0] nxt_clocks;
    logic       nxt_fault;
    logic       nxt_cl;
    logic [15:0] nxt_flags;

    // opcode and extension to kind, clocks and flag effects
    always_comb begin
        nxt_kind   = OPK_NONE;
        nxt_clocks = CLK_1;
        nxt_fault  = 1'b0;
        nxt_cl     = 1'b0;
        nxt_flags  = '0;   // all unchanged
        if (fin_op && state_ff == ST_ESC && cur_op == OP_SMENTRY) begin
            nxt_kind   = OPK_SMI;
            nxt_clocks = CLK_55;
        end else if (fin_op) begin
            case (cur_op)
                OP_SETCF: begin
                    nxt_kind = OPK_STC;
                    nxt_flags[2*FL_CF +: 2] = FX_ONE;
                end
                OP_SETDF: begin
                    nxt_kind   = OPK_STD;
                    nxt_clocks = CLK_7;
                    nxt_flags[2*FL_DF +: 2] = FX_ONE;
                end
                OP_SETIF: begin
                    nxt_kind   = OPK_STI;
                    nxt_clocks = CLK_7;
                    nxt_fault  = prot_mode && !iopl_ok;
                    nxt_flags[2*FL_IF +: 2] = nxt_fault ? FX_KEEP : FX_ONE;
                end
                default: nxt_kind = OPK_NONE;
            endcase
        end else if (fin_mrm && esc_ff) begin
            case (op_ff)
                OP_SETPAR: nxt_kind = (c_ext == EXT_000) ? OPK_SETPAR : OPK_NONE;
                OP_SETSGN: nxt_kind = (c_ext == EXT_000) ? OPK_SETSGN : OPK_NONE;
                OP_GRP_TBL: begin
                    if (c_ext == EXT_000) begin
                        nxt_kind   = OPK_SGT;
                        nxt_clocks = CLK_4;
                    end else if (c_ext == EXT_001) begin
                        nxt_kind   = OPK_SIT;
                        nxt_clocks = CLK_4;
                    end else if (c_ext == EXT_100) begin
                        nxt_kind   = OPK_SMW;
                        nxt_clocks = CLK_6;
                    end
                end
                OP_GRP_SEL: begin
                    if (c_ext == EXT_000 || c_ext == EXT_001) begin
                        nxt_kind   = (c_ext == EXT_000) ? OPK_SLS : OPK_STS;
                        nxt_clocks = (c_ext == EXT_000) ? CLK_1 : CLK_4;
                        nxt_fault  = !prot_mode;
                    end
                end
                OP_DLS_IMM, OP_DLS_CNT, OP_DRS_IMM, OP_DRS_CNT: begin
                    nxt_kind   = (op_ff[3]) ? OPK_DSR : OPK_DSL;
                    nxt_cl     = op_ff[0];
                    nxt_clocks = op_ff[0] ? CLK_5 : CLK_4;
                    nxt_flags  = {FX_WRITE, FX_WRITE, FX_UNDEF, FX_WRITE, FX_WRITE, FX_KEEP, FX_KEEP, FX_UNDEF};
                end
                default: nxt_kind = OPK_NONE;
            endcase
        end else if (fin_mrm && (c_ext == EXT_100 || c_ext == EXT_101)) begin
            nxt_kind   = (c_ext == EXT_100) ? OPK_SHL : OPK_SHR;
            nxt_cl     = (op_ff[7:1] == OP_SH_CNT);
            nxt_clocks = nxt_cl ? CLK_2 : CLK_1;
            nxt_flags  = {FX_WRITE, FX_WRITE, FX_UNDEF, FX_WRITE, FX_WRITE, FX_KEEP, FX_KEEP,
                          (op_ff[7:1] == OP_SH_ONE) ? FX_WRITE : FX_UNDEF};
        end
    end

    // ----------------------------------------------------------------
    // output registers
    // ----------------------------------------------------------------
    logic [1:0] nxt_size;
    always_comb begin
        if (nxt_kind == OPK_SHL || nxt_kind == OPK_SHR) begin
            nxt_size = !op_ff[0] ? 2'h0 : (op_size32 ? 2'h2 : 2'h1);
        end else if (nxt_kind == OPK_SETPAR || nxt_kind == OPK_SETSGN) begin
            nxt_size = 2'h0;   // one byte written
        end else begin
            nxt_size = op_size32 ? 2'h2 : 2'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dec_valid_ff  <= 1'b0;
            dec_kind_ff   <= OPK_NONE;
            dec_clocks_ff <= 6'h00;
            dec_fault_ff  <= 1'b0;
            dec_size_ff   <= 2'h0;
            dec_reg_op_ff <= 1'b0;
            dec_rm_ff     <= 3'h0;
            dec_imm_ff    <= 8'h00;
            dec_use_cl_ff <= 1'b0;
            dec_flags_ff  <= 16'h0000;
        end else begin
            dec_valid_ff <= done;
            if (done) begin
                dec_kind_ff   <= nxt_kind;
                dec_clocks_ff <= nxt_clocks;
                dec_fault_ff  <= nxt_fault;
                dec_size_ff   <= nxt_size;
                dec_reg_op_ff <= fin_mrm && (c_mod == MOD_REG);
                dec_rm_ff     <= c_rm;
                dec_imm_ff    <= (state_ff == ST_IMM) ? byte_data : 8'h00;   // shift count
                dec_use_cl_ff <= nxt_cl;
                dec_flags_ff  <= nxt_flags;
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_smi_clocks: assert property (@(posedge clk_sys) disable iff (rst)
        dec_valid_ff && dec_kind_ff == OPK_SMI |-> dec_clocks_ff == CLK_55)
        else $error("entry clocks wrong");
    a_sel_prot_only: assert property (@(posedge clk_sys) disable iff (rst)
        dec_valid_ff && (dec_kind_ff == OPK_SLS || dec_kind_ff == OPK_STS) |-> dec_fault_ff == !$past(prot_mode))
        else $error("selector store mode check wrong");
    a_table_clocks: assert property (@(posedge clk_sys) disable iff (rst)
        dec_valid_ff && (dec_kind_ff == OPK_SGT || dec_kind_ff == OPK_SIT) |-> dec_clocks_ff == CLK_4)
        else $error("table store clocks wrong");
    a_msw_clocks: assert property (@(posedge clk_sys) disable iff (rst)
        dec_valid_ff && dec_kind_ff == OPK_SMW |-> dec_clocks_ff == CLK_6)
        else $error("status word clocks wrong");
    a_shift_clocks: assert property (@(posedge clk_sys) disable iff (rst)
        dec_valid_ff && (dec_kind_ff == OPK_SHL || dec_kind_ff == OPK_SHR)
        |-> dec_clocks_ff == (dec_use_cl_ff ? CLK_2 : CLK_1))
        else $error("shift clocks wrong");
    a_dshift_flags: assert property (@(posedge clk_sys) disable iff (rst)
        dec_valid_ff && (dec_kind_ff == OPK_DSL || dec_kind_ff == OPK_DSR)
        |-> dec_flags_ff[2*FL_OF +: 2] == FX_UNDEF && dec_clocks_ff == (dec_use_cl_ff ? CLK_5 : CLK_4))
        else $error("double shift decode wrong");
    a_flag_set_only: assert property (@(posedge clk_sys) disable iff (rst)
        dec_valid_ff && dec_kind_ff == OPK_STC |-> dec_flags_ff == {FX_ONE, 14'h0000})
        else $error("carry set touches other flags");
    a_imm_one_byte: assert property (@(posedge clk_sys) disable iff (rst)
        byte_valid && state_ff == ST_IMM |=> state_ff == ST_OP && dec_valid_ff)
        else $error("immediate byte count wrong");
    a_byte_set: assert property (@(posedge clk_sys) disable iff (rst)
        dec_valid_ff && dec_kind_ff == OPK_SETPAR |-> dec_size_ff == 2'h0 && dec_clocks_ff == CLK_1)
        else $error("set byte decode wrong");
endmodule

// ==== sys_decode_pkg.sv ====
package sys_decode_pkg;
    localparam logic [7:0] OP_ESC      = 8'h0f;
    localparam logic [7:0] OP_SETPAR   = 8'h9a;
    localparam logic [7:0] OP_SETSGN   = 8'h98;
    localparam logic [7:0] OP_GRP_TBL  = 8'h01;
    localparam logic [7:0] OP_GRP_SEL  = 8'h00;
    localparam logic [7:0] OP_SMENTRY  = 8'h38;
    localparam logic [7:0] OP_DLS_IMM  = 8'ha4;
    localparam logic [7:0] OP_DLS_CNT  = 8'ha5;
    localparam logic [7:0] OP_DRS_IMM  = 8'hac;
    localparam logic [7:0] OP_DRS_CNT  = 8'had;
    localparam logic [6:0] OP_SH_ONE   = 7'h68;  // d0/d1 without w
    localparam logic [6:0] OP_SH_CNT   = 7'h69;  // d2/d3
    localparam logic [6:0] OP_SH_IMM   = 7'h60;  // c0/c1
    localparam logic [7:0] OP_SETCF    = 8'hf9;
    localparam logic [7:0] OP_SETDF    = 8'hfd;
    localparam logic [7:0] OP_SETIF    = 8'hfb;
    localparam logic [2:0] EXT_000     = 3'h0;
    localparam logic [2:0] EXT_001     = 3'h1;
    localparam logic [2:0] EXT_100     = 3'h4;
    localparam logic [2:0] EXT_101     = 3'h5;
    localparam logic [1:0] MOD_REG     = 2'h3;
    localparam logic [5:0] CLK_1       = 6'h01;
    localparam logic [5:0] CLK_2       = 6'h02;
    localparam logic [5:0] CLK_4       = 6'h04;
    localparam logic [5:0] CLK_5       = 6'h05;
    localparam logic [5:0] CLK_6       = 6'h06;
    localparam logic [5:0] CLK_7       = 6'h07;
    localparam logic [5:0] CLK_55      = 6'h37;
    // flag effect codes
    localparam logic [1:0] FX_KEEP     = 2'h0;
    localparam logic [1:0] FX_WRITE    = 2'h1;
    localparam logic [1:0] FX_UNDEF    = 2'h2;
    localparam logic [1:0] FX_ONE      = 2'h3;
    // flag slots in the effect vector
    localparam int FL_OF = 0;
    localparam int FL_DF = 1;
    localparam int FL_IF = 2;
    localparam int FL_SF = 3;
    localparam int FL_ZF = 4;
    localparam int FL_AF = 5;
    localparam int FL_PF = 6;
    localparam int FL_CF = 7;
    typedef enum logic [4:0] {
        OPK_NONE, OPK_SETPAR, OPK_SETSGN, OPK_SGT, OPK_SIT, OPK_SLS, OPK_STS, OPK_SMW,
        OPK_SMI, OPK_SHL, OPK_SHR, OPK_DSL, OPK_DSR, OPK_STC, OPK_STD, OPK_STI
    } op_kind_t;
    typedef enum { ST_OP, ST_ESC, ST_MODRM, ST_DISP, ST_IMM } dec_state_t;
endpackage

// ==== tb.sv ====
`timescale 1ns/1ps
module tb
    import sys_decode_pkg::*;
;
    // ----------------------------------------------------------------
    // signals and design
    // ----------------------------------------------------------------
    logic        clk_sys;
    logic        rst;
    logic        byte_valid;
    logic [7:0]  byte_data;
    logic [2:0]  disp_len;
    logic        prot_mode;
    logic        op_size32;
    logic        iopl_ok;
    logic        dec_valid_ff;
    op_kind_t    dec_kind_ff;
    logic [5:0]  dec_clocks_ff;
    logic        dec_fault_ff;
    logic [1:0]  dec_size_ff;
    logic        dec_reg_op_ff;
    logic [2:0]  dec_rm_ff;
    logic [7:0]  dec_imm_ff;
    logic        dec_use_cl_ff;
    logic [15:0] dec_flags_ff;
    int          miscompares;
    int          total_checks;
    logic [4:0]  kinds[$];                            // every decoded kind, in order
    localparam logic [1:0] FK = FX_KEEP;
    localparam logic [1:0] FW = FX_WRITE;
    localparam logic [1:0] FU = FX_UNDEF;
    localparam logic [1:0] F1 = FX_ONE;

    sys_decode i_sys_decode (.clk_sys(clk_sys), .rst(rst), .byte_valid(byte_valid), .byte_data(byte_data),
        .disp_len(disp_len), .prot_mode(prot_mode), .op_size32(op_size32), .iopl_ok(iopl_ok),
        .dec_valid_ff(dec_valid_ff), .dec_kind_ff(dec_kind_ff), .dec_clocks_ff(dec_clocks_ff),
        .dec_fault_ff(dec_fault_ff), .dec_size_ff(dec_size_ff), .dec_reg_op_ff(dec_reg_op_ff),
        .dec_rm_ff(dec_rm_ff), .dec_imm_ff(dec_imm_ff), .dec_use_cl_ff(dec_use_cl_ff),
        .dec_flags_ff(dec_flags_ff));

    // ----------------------------------------------------------------
    // clock, result recorder and watchdog
    // ----------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // the pulse lasts one cycle, so each result is seen once here
    always @(negedge clk_sys) begin
        if (dec_valid_ff === 1'b1) kinds.push_back(dec_kind_ff);
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        results();
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask
    function automatic logic [15:0] fx(input logic [1:0] o, d, i, s, z, a, p, c);
        fx = {c, p, a, z, s, i, d, o};                // slot 0 is overflow, slot 7 carry
    endfunction
    // one instruction byte, with the displacement count for a modrm byte
    task automatic put(input logic [7:0] b, input logic [2:0] dl = 3'h0);
        @(negedge clk_sys);
        byte_valid = 1'b1;
        byte_data  = b;
        disp_len   = dl;
    endtask
    // end the stream and wait a bounded time for the result pulse
    task automatic wv();
        int n;
        n = 0;
        @(negedge clk_sys);
        byte_valid = 1'b0;
        while (dec_valid_ff !== 1'b1 && n < 4) begin
            @(negedge clk_sys);
            n++;
        end
        check(dec_valid_ff, 16'h1, "valid");
    endtask
    task automatic res(input op_kind_t k, input logic [5:0] c, input logic f, input logic [15:0] fl);
        wv();
        check(dec_kind_ff, k, "kind");
        check(dec_clocks_ff, c, "clocks");
        check(dec_fault_ff, f, "fault");
        check(dec_flags_ff, fl, "flags");
    endtask
    task automatic operand(input logic [1:0] sz, input logic ro, input logic [2:0] rm, input logic [7:0] im);
        check(dec_size_ff, sz, "size");
        check(dec_reg_op_ff, ro, "reg op");
        check(dec_rm_ff, rm, "rm");
        check(dec_imm_ff, im, "imm");
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_flag_ops();
        put(OP_SETCF); res(OPK_STC, CLK_1, 1'b0, fx(FK, FK, FK, FK, FK, FK, FK, F1));
        put(OP_SETDF); res(OPK_STD, CLK_7, 1'b0, fx(FK, F1, FK, FK, FK, FK, FK, FK));
        put(OP_SETIF); res(OPK_STI, CLK_7, 1'b0, fx(FK, FK, F1, FK, FK, FK, FK, FK));
        prot_mode = 1'b1;
        put(OP_SETIF); res(OPK_STI, CLK_7, 1'b0, fx(FK, FK, F1, FK, FK, FK, FK, FK));
        iopl_ok = 1'b0;
        put(OP_SETIF); wv(); check(dec_fault_ff, 1'b1, "sti fault");
        check(dec_flags_ff, 16'h0, "sti flags");
        iopl_ok = 1'b1;
    endtask
    task automatic t_set_byte();
        put(OP_ESC); put(OP_SETPAR); put({MOD_REG, EXT_000, 3'h5});
        res(OPK_SETPAR, CLK_1, 1'b0, 16'h0); operand(2'h0, 1'b1, 3'h5, 8'h00);
        put(OP_ESC); put(OP_SETSGN); put({2'h0, EXT_000, 3'h3});
        res(OPK_SETSGN, CLK_1, 1'b0, 16'h0); operand(2'h0, 1'b0, 3'h3, 8'h00);
    endtask
    task automatic t_stores();
        logic [2:0] ext[3] = '{EXT_000, EXT_001, EXT_100};
        op_kind_t   k[3]   = '{OPK_SGT, OPK_SIT, OPK_SMW};
        logic [5:0] c[3]   = '{CLK_4, CLK_4, CLK_6};
        for (int m = 0; m < 2; m++) begin
            prot_mode = m[0];
            for (int i = 0; i < 3; i++) begin
                put(OP_ESC); put(OP_GRP_TBL); put({2'h0, ext[i], 3'h6}, 3'h2); put(8'h34); put(8'h12);
                res(k[i], c[i], 1'b0, 16'h0); check(dec_reg_op_ff, 1'b0, "mem op");
            end
            put(OP_ESC); put(OP_GRP_SEL); put({MOD_REG, EXT_000, 3'h1});
            if (m == 1) res(OPK_SLS, CLK_1, 1'b0, 16'h0);
            else begin wv(); check(dec_fault_ff, 1'b1, "sls real"); end
            put(OP_ESC); put(OP_GRP_SEL); put({2'h0, EXT_001, 3'h7});
            if (m == 1) res(OPK_STS, CLK_4, 1'b0, 16'h0);
            else begin wv(); check(dec_fault_ff, 1'b1, "sts real"); end
            put(OP_ESC); put(OP_SMENTRY); res(OPK_SMI, CLK_55, 1'b0, 16'h0);
        end
        put(OP_ESC); put(OP_GRP_TBL); put({MOD_REG, EXT_100, 3'h2});
        res(OPK_SMW, CLK_6, 1'b0, 16'h0); check(dec_reg_op_ff, 1'b1, "smw reg");
    endtask
    task automatic t_shifts();
        logic [7:0] op;
        for (int f = 0; f < 3; f++) for (int r = 0; r < 2; r++) for (int w = 0; w < 2; w++) begin
            op_size32 = r[0];
            op = {(f == 0) ? OP_SH_ONE : (f == 1) ? OP_SH_CNT : OP_SH_IMM, w[0]};
            put(op); put({MOD_REG, r[0] ? EXT_101 : EXT_100, 3'h2});
            if (f == 2) put(8'h1f);
            res(r[0] ? OPK_SHR : OPK_SHL, (f == 1) ? CLK_2 : CLK_1, 1'b0,
                fx((f == 0) ? FW : FU, FK, FK, FW, FW, FU, FW, FW));
            operand(w[0] ? (r[0] ? 2'h2 : 2'h1) : 2'h0, 1'b1, 3'h2, (f == 2) ? 8'h1f : 8'h00);
            check(dec_use_cl_ff, f == 1, "use cl");
        end
        put({OP_SH_IMM, 1'b0}); put({2'h1, EXT_100, 3'h3}, 3'h1); put(8'h80); put(8'h03);
        res(OPK_SHL, CLK_1, 1'b0, fx(FU, FK, FK, FW, FW, FU, FW, FW));
        operand(2'h0, 1'b0, 3'h3, 8'h03);
    endtask
    task automatic t_double();
        logic [7:0] ops[4] = '{OP_DLS_IMM, OP_DLS_CNT, OP_DRS_IMM, OP_DRS_CNT};
        for (int i = 0; i < 4; i++) begin
            put(OP_ESC); put(ops[i]); put({2'h2, 3'h1, 3'h0}, 3'h2); put(8'hd1); put(8'hd2);
            if (!i[0]) put(8'h07);
            res((i < 2) ? OPK_DSL : OPK_DSR, i[0] ? CLK_5 : CLK_4, 1'b0,
                fx(FU, FK, FK, FW, FW, FU, FW, FW));
            check(dec_imm_ff, i[0] ? 8'h00 : 8'h07, "dimm");
            check(dec_use_cl_ff, i[0], "duse cl");
        end
    endtask
    // unknown op then two flag ops, back to back with no gap
    task automatic t_back_to_back();
        @(negedge clk_sys);                                                             // let the last pulse pass
        kinds.delete();
        put(8'h90); put(OP_SETCF); put(OP_SETDF); wv();
        repeat (3) @(negedge clk_sys);
        check(kinds.size(), 16'h3, "count");
        if (kinds.size() == 3) begin
            check(kinds[0], OPK_NONE, "unknown");
            check(kinds[1], OPK_STC, "stc");
            check(kinds[2], OPK_STD, "std");
        end
    endtask
    // reset in mid-instruction drops the partial bytes
    task automatic t_mid_reset();
        put(OP_ESC); put(OP_GRP_TBL);
        @(negedge clk_sys);
        byte_valid = 1'b0;
        rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        check({dec_valid_ff, dec_clocks_ff}, 16'h0, "reset out");
        rst = 1'b0;
        put(OP_SETCF); res(OPK_STC, CLK_1, 1'b0, fx(FK, FK, FK, FK, FK, FK, FK, F1));
    endtask

    // ----------------------------------------------------------------
    // verdict and main sequence
    // ----------------------------------------------------------------
    task automatic results();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        {rst, byte_valid, byte_data, disp_len, prot_mode, op_size32} = '0;
        iopl_ok = 1'b1;
        miscompares = 0;
        total_checks = 0;
        rst = 1'b1;
        repeat (16) @(negedge clk_sys);
        check({dec_valid_ff, dec_fault_ff, dec_flags_ff[13:0]}, 16'h0, "reset");
        rst = 1'b0;
        t_flag_ops();
        t_set_byte();
        t_stores();
        t_shifts();
        t_double();
        t_back_to_back();
        t_mid_reset();
        results();
    end
endmodule
